// ==== design/pwr_cmd_regs.vh ====
// Command codes, reset values and field positions of the command map
`ifndef PWR_CMD_REGS_VH
`define PWR_CMD_REGS_VH

`define CMD_COMM_MEMORY_STATUS 8'h7e
`define CMD_VENDOR_FAULT_STATE 8'h80
`define CMD_INPUT_VOLTAGE 8'h88
`define CMD_OUTPUT_VOLTAGE 8'h8b
`define CMD_DIE_TEMPERATURE 8'h8d
`define CMD_PROTOCOL_REVISION 8'h98
`define CMD_TOOL_WORD_A 8'hb0
`define CMD_TOOL_WORD_B 8'hb1
`define CMD_OEM_WORD 8'hb2
`define CMD_SCRATCH_PAGED 8'hb3
`define CMD_SCRATCH_GLOBAL 8'hb4
`define CMD_VENDOR_WORD_A 8'hb5
`define CMD_VENDOR_INFORMATION 8'hb6
`define CMD_EXTRA_FAULT_STATE 8'hb7
`define CMD_VENDOR_WORD_B 8'hbc
`define CMD_NVM_UNLOCK 8'hbd
`define CMD_NVM_ERASE 8'hbe
`define CMD_NVM_DATA_PORT 8'hbf
`define CMD_ALT_COMMAND_PORT 8'hc0
`define CMD_ALT_HOST0_DATA 8'hc1
`define CMD_ALT_HOST1_DATA 8'hc2
`define CMD_TELEMETRY_BLOCK 8'hcf
`define CMD_CHANNEL_CONFIG 8'hd0
`define CMD_GLOBAL_CONFIG 8'hd1
`define CMD_FAULT_PAIR_A 8'hd2
`define CMD_FAULT_PAIR_B 8'hd3
`define CMD_POWER_GOOD_MAP 8'hd4

`define RST_ZERO16 16'h0000
`define RST_CHANNEL_CONFIG 16'h0080
`define RST_GLOBAL_CONFIG 16'h1c7b
`define RST_FAULT_PROPAGATE 8'h00
`define RST_POWER_GOOD_MAP 16'h0000
`define RST_UNLOCK 8'h00
`define RST_STATUS 8'h00

// Communication status bit raised on an invalid access
`define CML_INVALID_BIT 7
// Communication status bit raised on an unknown command code
`define CML_UNKNOWN_BIT 6
// Memory status bit raised on a refused nonvolatile access
`define CML_MEMORY_BIT 4
// Power good map: bits 7..0 channels, bit 8 watchdog/reset status
`define PGMAP_WDOG_BIT 8
// Telemetry block: byte count, then one word per channel
`define TELEM_BYTE_COUNT_POS 0

`endif

// ==== design/power_manager_command_map.v ====
// Command-addressed register bank of an eight-channel supply manager
`timescale 1ns/1ps
`include "pwr_cmd_regs.vh"

module power_manager_command_map #(
    parameter CHANNELS = 8,
    parameter PAGE_W = 3,
    parameter NVM_WORDS = 64,
    parameter NVM_AW = 6,
    parameter [7:0] UNLOCK_KEY = 8'h2b,
    // Arbitrary value, stands in for the revision identification
    parameter [7:0] REVISION_CODE = 8'h5a,
    // Arbitrary value
    parameter [15:0] INFO_CODE = 16'h1234
) (
    input wire mclk_i,
    input wire resetn_i,
    input wire [PAGE_W-1:0] page_i,
    input wire cmd_wr_i,
    input wire cmd_rd_i,
    input wire [7:0] cmd_code_i,
    input wire [15:0] cmd_wdata_i,
    input wire [4:0] blk_index_i,
    input wire comm_status_clear_i,
    input wire [7:0] vendor_state_i,
    input wire [15:0] extra_state_i,
    input wire [15:0] vin_i,
    input wire [15:0] temp_i,
    input wire [16*CHANNELS-1:0] vout_i,
    input wire [CHANNELS-1:0] faulted_off_i,
    input wire [CHANNELS-1:0] power_good_i,
    input wire watchdog_status_i,
    output reg [15:0] cmd_rdata_o,
    output reg cmd_ack_o,
    output reg cmd_refused_o,
    output reg [7:0] comm_memory_status_o,
    output reg nvm_erase_o,
    output reg nvm_write_o,
    output reg [NVM_AW-1:0] nvm_addr_o,
    output reg [15:0] nvm_wdata_o,
    output reg [15:0] alt_command_o,
    output reg alt_command_strobe_o,
    output reg fault_line_a0_o,
    output reg fault_line_a1_o,
    output reg fault_line_b0_o,
    output reg fault_line_b1_o,
    output reg power_good_output_o
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    reg [15:0] chan_cfg_q [0:CHANNELS-1];
    reg [15:0] tool_b_q [0:CHANNELS-1];
    reg [15:0] scratch_p_q [0:CHANNELS-1];
    reg [15:0] vend_a_q [0:CHANNELS-1];
    reg [15:0] vend_b_q [0:CHANNELS-1];
    reg [7:0] prop_a_q [0:CHANNELS-1];
    reg [7:0] prop_b_q [0:CHANNELS-1];
    reg [15:0] nvm_mem_q [0:NVM_WORDS-1];
    reg [15:0] tool_a_q;
    reg [15:0] oem_q;
    reg [15:0] scratch_g_q;
    reg [15:0] global_cfg_q;
    reg [15:0] pg_map_q;
    reg [7:0] unlock_q;
    reg [15:0] alt0_q;
    reg [15:0] alt1_q;
    reg [NVM_AW-1:0] nvm_ptr_q;
    integer i;
    integer k;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function is_read_only;
        input [7:0] code;
        begin
            case (code)
                `CMD_COMM_MEMORY_STATUS, `CMD_VENDOR_FAULT_STATE,
                `CMD_INPUT_VOLTAGE, `CMD_OUTPUT_VOLTAGE,
                `CMD_DIE_TEMPERATURE, `CMD_PROTOCOL_REVISION,
                `CMD_VENDOR_INFORMATION, `CMD_EXTRA_FAULT_STATE,
                `CMD_TELEMETRY_BLOCK: is_read_only = 1'b1;
                default: is_read_only = 1'b0;
            endcase
        end
    endfunction

    function is_known;
        input [7:0] code;
        begin
            case (code)
                `CMD_TOOL_WORD_A, `CMD_TOOL_WORD_B, `CMD_OEM_WORD,
                `CMD_SCRATCH_PAGED, `CMD_SCRATCH_GLOBAL,
                `CMD_VENDOR_WORD_A, `CMD_VENDOR_WORD_B,
                `CMD_NVM_UNLOCK, `CMD_NVM_ERASE, `CMD_NVM_DATA_PORT,
                `CMD_ALT_COMMAND_PORT, `CMD_ALT_HOST0_DATA,
                `CMD_ALT_HOST1_DATA, `CMD_CHANNEL_CONFIG,
                `CMD_GLOBAL_CONFIG, `CMD_FAULT_PAIR_A,
                `CMD_FAULT_PAIR_B, `CMD_POWER_GOOD_MAP: is_known = 1'b1;
                default: is_known = is_read_only(code);
            endcase
        end
    endfunction

    function [15:0] vout_of;
        input [16*CHANNELS-1:0] all;
        input [PAGE_W-1:0] ch;
        begin
            vout_of = all[ch*16 +: 16];
        end
    endfunction

    wire unlocked = (unlock_q == UNLOCK_KEY);
    wire nvm_cmd = (cmd_code_i == `CMD_NVM_ERASE) ||
                   (cmd_code_i == `CMD_NVM_DATA_PORT);
    wire refuse = nvm_cmd && !unlocked && (cmd_wr_i || cmd_rd_i);
    wire ro_write = cmd_wr_i && is_read_only(cmd_code_i);
    wire unknown = (cmd_wr_i || cmd_rd_i) && !is_known(cmd_code_i);

    // ------------------------------------------------------------
    // Telemetry block
    // ------------------------------------------------------------
    // Index 0 is the byte count, then each channel as low, high byte
    localparam [31:0] TELEM_BYTES = 2 * CHANNELS;
    reg [7:0] telem_byte;
    reg [PAGE_W-1:0] telem_ch;
    reg [15:0] telem_word;
    always @* begin
        telem_ch = blk_index_i[PAGE_W:1] - 1'b1;
        if (blk_index_i[0]) begin
            telem_ch = blk_index_i[PAGE_W:1];
        end
        telem_word = vout_of(vout_i, telem_ch);
        if (blk_index_i == `TELEM_BYTE_COUNT_POS) begin
            telem_byte = TELEM_BYTES[7:0];
        end else if (blk_index_i > TELEM_BYTES) begin
            telem_byte = 8'h00;
        end else if (blk_index_i[0]) begin
            telem_byte = telem_word[7:0];
        end else begin
            telem_byte = telem_word[15:8];
        end
    end

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    reg [15:0] rd_d;
    always @* begin
        case (cmd_code_i)
            `CMD_COMM_MEMORY_STATUS:
                rd_d = {8'h00, comm_memory_status_o};
            `CMD_VENDOR_FAULT_STATE: rd_d = {8'h00, vendor_state_i};
            `CMD_INPUT_VOLTAGE: rd_d = vin_i;
            `CMD_OUTPUT_VOLTAGE: rd_d = vout_of(vout_i, page_i);
            `CMD_DIE_TEMPERATURE: rd_d = temp_i;
            `CMD_PROTOCOL_REVISION: rd_d = {8'h00, REVISION_CODE};
            `CMD_TOOL_WORD_A: rd_d = tool_a_q;
            `CMD_TOOL_WORD_B: rd_d = tool_b_q[page_i];
            `CMD_OEM_WORD: rd_d = oem_q;
            `CMD_SCRATCH_PAGED: rd_d = scratch_p_q[page_i];
            `CMD_SCRATCH_GLOBAL: rd_d = scratch_g_q;
            `CMD_VENDOR_WORD_A: rd_d = vend_a_q[page_i];
            `CMD_VENDOR_INFORMATION: rd_d = INFO_CODE;
            `CMD_EXTRA_FAULT_STATE: rd_d = extra_state_i;
            `CMD_VENDOR_WORD_B: rd_d = vend_b_q[page_i];
            `CMD_NVM_UNLOCK: rd_d = {8'h00, unlock_q};
            `CMD_NVM_ERASE: rd_d = `RST_ZERO16;
            `CMD_NVM_DATA_PORT: rd_d = nvm_mem_q[nvm_ptr_q];
            `CMD_ALT_COMMAND_PORT: rd_d = alt_command_o;
            `CMD_ALT_HOST0_DATA: rd_d = alt0_q;
            `CMD_ALT_HOST1_DATA: rd_d = alt1_q;
            `CMD_TELEMETRY_BLOCK: rd_d = {8'h00, telem_byte};
            `CMD_CHANNEL_CONFIG: rd_d = chan_cfg_q[page_i];
            `CMD_GLOBAL_CONFIG: rd_d = global_cfg_q;
            `CMD_FAULT_PAIR_A: rd_d = {8'h00, prop_a_q[page_i]};
            `CMD_FAULT_PAIR_B: rd_d = {8'h00, prop_b_q[page_i]};
            `CMD_POWER_GOOD_MAP: rd_d = pg_map_q;
            default: rd_d = `RST_ZERO16;
        endcase
    end

    // ------------------------------------------------------------
    // Pin combining
    // ------------------------------------------------------------
    reg prop_a_d;
    reg prop_b_d;
    reg pg_d;
    always @* begin
        prop_a_d = 1'b0;
        prop_b_d = 1'b0;
        pg_d = 1'b1;
        for (i = 0; i < CHANNELS; i = i + 1) begin
            if (prop_a_q[i][0] && faulted_off_i[i]) begin
                prop_a_d = 1'b1;
            end
            if (prop_b_q[i][0] && faulted_off_i[i]) begin
                prop_b_d = 1'b1;
            end
            if (pg_map_q[i] && !power_good_i[i]) begin
                pg_d = 1'b0;
            end
        end
        if (pg_map_q[`PGMAP_WDOG_BIT] && !watchdog_status_i) begin
            pg_d = 1'b0;
        end
    end

    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            fault_line_a0_o <= 1'b0;
            fault_line_a1_o <= 1'b0;
            fault_line_b0_o <= 1'b0;
            fault_line_b1_o <= 1'b0;
            power_good_output_o <= 1'b0;
        end else begin
            fault_line_a0_o <= prop_a_d;
            fault_line_a1_o <= prop_a_d;
            fault_line_b0_o <= prop_b_d;
            fault_line_b1_o <= prop_b_d;
            power_good_output_o <= pg_d;
        end
    end

    // ------------------------------------------------------------
    // Communication and memory status
    // ------------------------------------------------------------
    // Bits are sticky; a set wins over a clear in the same cycle
    reg [7:0] status_d;
    always @* begin
        status_d = comm_memory_status_o;
        if (comm_status_clear_i) begin
            status_d = `RST_STATUS;
        end
        if (ro_write) begin
            status_d[`CML_INVALID_BIT] = 1'b1;
        end
        if (unknown) begin
            status_d[`CML_UNKNOWN_BIT] = 1'b1;
        end
        if (refuse) begin
            status_d[`CML_MEMORY_BIT] = 1'b1;
        end
    end

    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            comm_memory_status_o <= `RST_STATUS;
        end else begin
            comm_memory_status_o <= status_d;
        end
    end

    // ------------------------------------------------------------
    // Data port pointer
    // ------------------------------------------------------------
    // An accepted erase rewinds it, each accepted word moves it on
    wire nvm_wipe = cmd_wr_i && !refuse &&
                    (cmd_code_i == `CMD_NVM_ERASE);
    wire nvm_word = (cmd_wr_i || cmd_rd_i) && !refuse &&
                    (cmd_code_i == `CMD_NVM_DATA_PORT);
    reg [NVM_AW-1:0] nvm_ptr_d;
    always @* begin
        nvm_ptr_d = nvm_ptr_q;
        if (nvm_wipe) begin
            nvm_ptr_d = {NVM_AW{1'b0}};
        end else if (nvm_word) begin
            nvm_ptr_d = nvm_ptr_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Register writes and status
    // ------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            for (k = 0; k < CHANNELS; k = k + 1) begin
                chan_cfg_q[k] <= `RST_CHANNEL_CONFIG;
                tool_b_q[k] <= `RST_ZERO16;
                scratch_p_q[k] <= `RST_ZERO16;
                vend_a_q[k] <= `RST_ZERO16;
                vend_b_q[k] <= `RST_ZERO16;
                prop_a_q[k] <= `RST_FAULT_PROPAGATE;
                prop_b_q[k] <= `RST_FAULT_PROPAGATE;
            end
            tool_a_q <= `RST_ZERO16;
            oem_q <= `RST_ZERO16;
            scratch_g_q <= `RST_ZERO16;
            global_cfg_q <= `RST_GLOBAL_CONFIG;
            pg_map_q <= `RST_POWER_GOOD_MAP;
            unlock_q <= `RST_UNLOCK;
            alt0_q <= `RST_ZERO16;
            alt1_q <= `RST_ZERO16;
            alt_command_o <= `RST_ZERO16;
            alt_command_strobe_o <= 1'b0;
            nvm_ptr_q <= {NVM_AW{1'b0}};
            nvm_erase_o <= 1'b0;
            nvm_write_o <= 1'b0;
            nvm_addr_o <= {NVM_AW{1'b0}};
            nvm_wdata_o <= `RST_ZERO16;
            cmd_rdata_o <= `RST_ZERO16;
            cmd_ack_o <= 1'b0;
            cmd_refused_o <= 1'b0;
        end else begin
            cmd_ack_o <= cmd_wr_i || cmd_rd_i;
            cmd_refused_o <= refuse || ro_write;
            cmd_rdata_o <= (cmd_rd_i && !refuse) ? rd_d : `RST_ZERO16;
            alt_command_strobe_o <= 1'b0;
            nvm_erase_o <= 1'b0;
            nvm_write_o <= 1'b0;
            nvm_ptr_q <= nvm_ptr_d;
            if (cmd_wr_i && !refuse && !ro_write) begin
                case (cmd_code_i)
                    `CMD_TOOL_WORD_A: tool_a_q <= cmd_wdata_i;
                    `CMD_TOOL_WORD_B: tool_b_q[page_i] <= cmd_wdata_i;
                    `CMD_OEM_WORD: oem_q <= cmd_wdata_i;
                    `CMD_SCRATCH_PAGED:
                        scratch_p_q[page_i] <= cmd_wdata_i;
                    `CMD_SCRATCH_GLOBAL: scratch_g_q <= cmd_wdata_i;
                    `CMD_VENDOR_WORD_A: vend_a_q[page_i] <= cmd_wdata_i;
                    `CMD_VENDOR_WORD_B: vend_b_q[page_i] <= cmd_wdata_i;
                    `CMD_NVM_UNLOCK: unlock_q <= cmd_wdata_i[7:0];
                    `CMD_NVM_ERASE: begin
                        for (k = 0; k < NVM_WORDS; k = k + 1) begin
                            nvm_mem_q[k] <= `RST_ZERO16;
                        end
                        nvm_erase_o <= 1'b1;
                    end
                    `CMD_NVM_DATA_PORT: begin
                        nvm_mem_q[nvm_ptr_q] <= cmd_wdata_i;
                        nvm_addr_o <= nvm_ptr_q;
                        nvm_wdata_o <= cmd_wdata_i;
                        nvm_write_o <= 1'b1;
                    end
                    `CMD_ALT_COMMAND_PORT: begin
                        alt_command_o <= cmd_wdata_i;
                        alt_command_strobe_o <= 1'b1;
                    end
                    `CMD_ALT_HOST0_DATA: alt0_q <= cmd_wdata_i;
                    `CMD_ALT_HOST1_DATA: alt1_q <= cmd_wdata_i;
                    `CMD_CHANNEL_CONFIG:
                        chan_cfg_q[page_i] <= cmd_wdata_i;
                    `CMD_GLOBAL_CONFIG: global_cfg_q <= cmd_wdata_i;
                    `CMD_FAULT_PAIR_A:
                        prop_a_q[page_i] <= cmd_wdata_i[7:0];
                    `CMD_FAULT_PAIR_B:
                        prop_b_q[page_i] <= cmd_wdata_i[7:0];
                    `CMD_POWER_GOOD_MAP: pg_map_q <= cmd_wdata_i;
                    default: ;
                endcase
            end
        end
    end

endmodule

// ==== sim/pm_cmd_map_props.sv ====
// Concurrent checks on the ports of the command register bank
`timescale 1ns/1ps
`include "pwr_cmd_regs.vh"
module pm_cmd_map_props #(
    parameter CHANNELS = 8,
    parameter [7:0] REVISION_CODE = 8'h5a
) (
    input wire mclk_i,
    input wire resetn_i,
    input wire cmd_wr_i,
    input wire cmd_rd_i,
    input wire [7:0] cmd_code_i,
    input wire [4:0] blk_index_i,
    input wire comm_status_clear_i,
    input wire [15:0] cmd_rdata_o,
    input wire cmd_ack_o,
    input wire cmd_refused_o,
    input wire [7:0] comm_memory_status_o,
    input wire nvm_erase_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    // ------------------------------------------------------------
    // Command handshake, read-only, erase, status and telemetry behaviour
    // ------------------------------------------------------------
    ack_follows_strobe_a: assert property ((cmd_wr_i || cmd_rd_i) |=>
        cmd_ack_o) else $error("strobe without acknowledge");
    ack_has_cause_a: assert property (cmd_ack_o |->
        ($past(cmd_wr_i) || $past(cmd_rd_i)))
        else $error("stray acknowledge");
    refuse_with_ack_a: assert property (cmd_refused_o |-> cmd_ack_o)
        else $error("refusal without acknowledge");
    rdata_idle_zero_a: assert property (!$past(cmd_rd_i) |->
        cmd_rdata_o == 16'h0000) else $error("read data outside a read");
    ro_write_flag_a: assert property (cmd_wr_i &&
        cmd_code_i == `CMD_PROTOCOL_REVISION |=> cmd_refused_o &&
        comm_memory_status_o[`CML_INVALID_BIT]) else $error("ro write kept");
    revision_fixed_a: assert property (cmd_rd_i &&
        cmd_code_i == `CMD_PROTOCOL_REVISION |=>
        cmd_rdata_o == {8'h00, REVISION_CODE}) else $error("bad revision");
    erase_cause_a: assert property (nvm_erase_o |-> cmd_ack_o &&
        !cmd_refused_o && $past(cmd_code_i) == `CMD_NVM_ERASE)
        else $error("erase without accepted erase write");
    status_sticky_a: assert property (
        $fell(comm_memory_status_o[`CML_INVALID_BIT]) |->
        $past(comm_status_clear_i)) else $error("status bit lost");
    telem_count_a: assert property (cmd_rd_i && blk_index_i == 5'h00 &&
        cmd_code_i == `CMD_TELEMETRY_BLOCK |=> cmd_rdata_o == 2 * CHANNELS)
        else $error("bad telemetry byte count");
endmodule

bind power_manager_command_map pm_cmd_map_props #(.CHANNELS(CHANNELS),
    .REVISION_CODE(REVISION_CODE)) pm_cmd_map_props_inst (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .cmd_wr_i(cmd_wr_i),
    .cmd_rd_i(cmd_rd_i), .cmd_code_i(cmd_code_i), .blk_index_i(blk_index_i),
    .comm_status_clear_i(comm_status_clear_i), .cmd_rdata_o(cmd_rdata_o),
    .cmd_ack_o(cmd_ack_o), .cmd_refused_o(cmd_refused_o),
    .comm_memory_status_o(comm_memory_status_o), .nvm_erase_o(nvm_erase_o));

// ==== sim/host_model.sv ====
// Host side model that issues word accesses to the register bank
`timescale 1ns/1ps
module host_model (
    input wire mclk_i,
    output reg cmd_wr_o,
    output reg cmd_rd_o,
    output reg [7:0] cmd_code_o,
    output reg [15:0] cmd_wdata_o,
    input wire [15:0] cmd_rdata_i,
    input wire cmd_refused_i,
    output reg [15:0] rdata_o,
    output reg refused_o
);
    initial begin
        cmd_wr_o = 1'b0;
        cmd_rd_o = 1'b0;
        cmd_code_o = 8'h00;
        cmd_wdata_o = 16'h0000;
    end
    // ------------------------------------------------------------
    // One word access, launched and closed on falling edges
    // ------------------------------------------------------------
    task xfer(input wr, input [7:0] code, input [15:0] data);
        begin
            @(negedge mclk_i);
            cmd_wr_o = wr;
            cmd_rd_o = !wr;
            cmd_code_o = code;
            cmd_wdata_o = data;
            @(negedge mclk_i);
            rdata_o = cmd_rdata_i;
            refused_o = cmd_refused_i;
            cmd_wr_o = 1'b0;
            cmd_rd_o = 1'b0;
            // Idle bus shows inverted values, never a stale copy
            cmd_code_o = ~code;
            cmd_wdata_o = ~data;
        end
    endtask
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench of the command register bank
`timescale 1ns/1ps
`include "pwr_cmd_regs.vh"
module testbench;
    reg mclk_i = 1'b0;
    reg resetn_i = 1'b0;
    reg [2:0] page_i = 3'h0;
    reg [4:0] blk_index_i = 5'h00;
    reg comm_status_clear_i = 1'b0;
    reg [7:0] vendor_state_i = 8'h9c;
    reg [15:0] extra_state_i = 16'h4e21;
    reg [15:0] vin_i = 16'hd3c1;
    reg [15:0] temp_i = 16'he2a7;
    reg [127:0] vout_i = 128'h7007_6006_5005_4004_3a03_2002_1001_0c00;
    reg [7:0] faulted_off_i = 8'h00;
    reg [7:0] power_good_i = 8'h00;
    reg watchdog_status_i = 1'b1;
    wire [15:0] cmd_rdata_o, nvm_wdata_o, alt_command_o, cmd_wdata_i, hrd;
    wire [7:0] comm_memory_status_o, cmd_code_i;
    wire [5:0] nvm_addr_o;
    wire cmd_ack_o, cmd_refused_o, nvm_erase_o, nvm_write_o, href;
    wire alt_command_strobe_o, power_good_output_o, cmd_wr_i, cmd_rd_i;
    wire fault_line_a0_o, fault_line_a1_o, fault_line_b0_o, fault_line_b1_o;
    wire [31:0] nvm_view = {9'h0, nvm_write_o, nvm_addr_o, nvm_wdata_o};
    wire [31:0] alt_view = {15'h0, alt_command_strobe_o, alt_command_o};
    integer num_errors = 0;
    integer n_checks = 0;
    always #2.5 mclk_i = ~mclk_i;
    power_manager_command_map power_manager_command_map_inst (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .page_i(page_i),
        .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i), .cmd_code_i(cmd_code_i),
        .cmd_wdata_i(cmd_wdata_i), .blk_index_i(blk_index_i),
        .comm_status_clear_i(comm_status_clear_i),
        .vendor_state_i(vendor_state_i), .extra_state_i(extra_state_i),
        .vin_i(vin_i), .temp_i(temp_i), .vout_i(vout_i),
        .faulted_off_i(faulted_off_i), .power_good_i(power_good_i),
        .watchdog_status_i(watchdog_status_i), .cmd_rdata_o(cmd_rdata_o),
        .cmd_ack_o(cmd_ack_o), .cmd_refused_o(cmd_refused_o),
        .comm_memory_status_o(comm_memory_status_o),
        .nvm_erase_o(nvm_erase_o), .nvm_write_o(nvm_write_o),
        .nvm_addr_o(nvm_addr_o), .nvm_wdata_o(nvm_wdata_o),
        .alt_command_o(alt_command_o),
        .alt_command_strobe_o(alt_command_strobe_o),
        .fault_line_a0_o(fault_line_a0_o), .fault_line_a1_o(fault_line_a1_o),
        .fault_line_b0_o(fault_line_b0_o), .fault_line_b1_o(fault_line_b1_o),
        .power_good_output_o(power_good_output_o));
    host_model host_model_inst (.mclk_i(mclk_i), .cmd_wr_o(cmd_wr_i),
        .cmd_rd_o(cmd_rd_i), .cmd_code_o(cmd_code_i),
        .cmd_wdata_o(cmd_wdata_i), .cmd_rdata_i(cmd_rdata_o),
        .cmd_refused_i(cmd_refused_o), .rdata_o(hrd), .refused_o(href));
    // ------------------------------------------------------------
    // Compare, access and closing tasks
    // ------------------------------------------------------------
    task chk(input [31:0] got, input [31:0] exp, input [8*12-1:0] msg);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("unexpected at %0t: %0s", $time, msg);
            end
        end
    endtask
    task wr(input [7:0] code, input [15:0] data, input ref_exp);
        begin
            host_model_inst.xfer(1'b1, code, data);
            chk({31'h0, href}, {31'h0, ref_exp}, "refusal");
        end
    endtask
    task rd(input [7:0] code, input [15:0] exp);
        begin
            host_model_inst.xfer(1'b0, code, 16'h0000);
            chk({16'h0, hrd}, {16'h0, exp}, "read data");
        end
    endtask
    task pins(input [4:0] exp);
        begin
            repeat (2) @(negedge mclk_i);
            chk({27'h0, fault_line_a0_o, fault_line_a1_o, fault_line_b0_o,
                fault_line_b1_o, power_good_output_o}, {27'h0, exp}, "pins");
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", n_checks, num_errors);
            if (num_errors == 0 && n_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        #20000;
        num_errors = num_errors + 1;
        conclude;
    end
    initial begin
        repeat (10) @(negedge mclk_i);
        resetn_i = 1'b1;
        rd(`CMD_CHANNEL_CONFIG, `RST_CHANNEL_CONFIG);
        rd(`CMD_GLOBAL_CONFIG, `RST_GLOBAL_CONFIG);
        rd(`CMD_FAULT_PAIR_A, 16'h0000);
        rd(`CMD_FAULT_PAIR_B, 16'h0000);
        rd(`CMD_POWER_GOOD_MAP, `RST_POWER_GOOD_MAP);
        rd(`CMD_PROTOCOL_REVISION, 16'h005a);
        $display("test defaults done");
        page_i = 3'h3;
        wr(`CMD_CHANNEL_CONFIG, 16'h0a5f, 1'b0);
        wr(`CMD_GLOBAL_CONFIG, 16'h1c00, 1'b0);
        rd(`CMD_CHANNEL_CONFIG, 16'h0a5f);
        rd(`CMD_OUTPUT_VOLTAGE, vout_i[63:48]);
        page_i = 3'h0;
        rd(`CMD_CHANNEL_CONFIG, `RST_CHANNEL_CONFIG);
        rd(`CMD_GLOBAL_CONFIG, 16'h1c00);
        rd(`CMD_OUTPUT_VOLTAGE, vout_i[15:0]);
        rd(`CMD_INPUT_VOLTAGE, vin_i);
        rd(`CMD_DIE_TEMPERATURE, temp_i);
        rd(`CMD_VENDOR_FAULT_STATE, {8'h00, vendor_state_i});
        rd(`CMD_EXTRA_FAULT_STATE, extra_state_i);
        $display("test paging and telemetry words done");
        wr(`CMD_PROTOCOL_REVISION, 16'h00ff, 1'b1);
        rd(`CMD_PROTOCOL_REVISION, 16'h005a);
        rd(`CMD_COMM_MEMORY_STATUS, 16'h0080);
        wr(8'h81, 16'h0000, 1'b0);
        rd(8'h81, 16'h0000);
        rd(`CMD_COMM_MEMORY_STATUS, 16'h00c0);
        @(negedge mclk_i) comm_status_clear_i = 1'b1;
        @(negedge mclk_i) comm_status_clear_i = 1'b0;
        rd(`CMD_COMM_MEMORY_STATUS, 16'h0000);
        $display("test read-only writes done");
        wr(`CMD_NVM_ERASE, 16'h0000, 1'b1);
        rd(`CMD_COMM_MEMORY_STATUS, 16'h0010);
        wr(`CMD_NVM_UNLOCK, 16'h002b, 1'b0);
        wr(`CMD_NVM_DATA_PORT, 16'hbeef, 1'b0);
        chk(nvm_view, 32'h0040beef, "w0");
        wr(`CMD_NVM_DATA_PORT, 16'h1234, 1'b0);
        chk(nvm_view, 32'h00411234, "w1");
        wr(`CMD_NVM_ERASE, 16'h0000, 1'b0);
        chk({31'h0, nvm_erase_o}, 32'h1, "erase");
        wr(`CMD_NVM_DATA_PORT, 16'h00a5, 1'b0);
        chk(nvm_view, 32'h004000a5, "w2");
        rd(`CMD_NVM_DATA_PORT, 16'h0000);
        wr(`CMD_NVM_DATA_PORT, 16'h5a5a, 1'b0);
        chk(nvm_view, 32'h00425a5a, "w3");
        $display("test nonvolatile port done");
        wr(`CMD_ALT_COMMAND_PORT, 16'h00cf, 1'b0);
        chk(alt_view, 32'h100cf, "alt");
        wr(`CMD_ALT_HOST0_DATA, 16'h1111, 1'b0);
        wr(`CMD_ALT_HOST1_DATA, 16'h2222, 1'b0);
        rd(`CMD_ALT_HOST0_DATA, 16'h1111);
        rd(`CMD_ALT_HOST1_DATA, 16'h2222);
        rd(`CMD_TELEMETRY_BLOCK, 16'h0010);
        blk_index_i = 5'd5;
        rd(`CMD_TELEMETRY_BLOCK, {8'h00, vout_i[39:32]});
        blk_index_i = 5'd6;
        rd(`CMD_TELEMETRY_BLOCK, {8'h00, vout_i[47:40]});
        blk_index_i = 5'd17;
        rd(`CMD_TELEMETRY_BLOCK, 16'h0000);
        $display("test alternate and block done");
        pins(5'h01);
        page_i = 3'h1;
        faulted_off_i = 8'h02;
        wr(`CMD_FAULT_PAIR_A, 16'h0001, 1'b0);
        pins(5'h19);
        wr(`CMD_FAULT_PAIR_B, 16'h0001, 1'b0);
        pins(5'h1f);
        wr(`CMD_POWER_GOOD_MAP, 16'h0106, 1'b0);
        pins(5'h1e);
        power_good_i = 8'h06;
        pins(5'h1f);
        watchdog_status_i = 1'b0;
        pins(5'h1e);
        $display("test pins done");
        conclude;
    end
endmodule
